// ---- tcsm_regs.svh ----
// Purpose: addresses, field positions, reset values and counts of the timer clock/mode front end
// Assumes: 20-bit cpu byte addresses, 16-bit data
// Notes: definitions only
`ifndef TCSM_REGS_SVH
`define TCSM_REGS_SVH

`define TCSM_MODE0_ADDR 20'hf0190
`define TCSM_MODE_LAST_ADDR 20'hf019e
`define TCSM_PSEL_ADDR 20'hf01b6

`define TCSM_MODE_RESET 16'h0000
`define TCSM_PSEL_RESET 8'h00
// unused mode bits 14, 13, 5, 4 hold zero
`define TCSM_MODE_WMASK 16'h9fcf

`define TCSM_CLKA_HI 3
`define TCSM_CLKA_LO 0
`define TCSM_CLKB_HI 7
`define TCSM_CLKB_LO 4

`define TCSM_CKS_BIT 15
`define TCSM_CCS_BIT 12
`define TCSM_LEAD_BIT 11
`define TCSM_TRIG_HI 10
`define TCSM_TRIG_LO 8
`define TCSM_EDGE_HI 7
`define TCSM_EDGE_LO 6
`define TCSM_MD_HI 3
`define TCSM_MD_LO 0

// subsystem clock edges per count pulse, minus one
`define TCSM_FSUB_DIV 2'h3

`endif

// ---- tcsm_pkg.sv ----
// Purpose: types of the timer clock/mode front end
// Assumes: eight channels
// Notes: field decodes are registered in the top module
package tcsm_pkg;

    typedef enum logic [2:0] {
        tcsm_md_interval,
        tcsm_md_capture,
        tcsm_md_event,
        tcsm_md_one_count,
        tcsm_md_capture_one,
        tcsm_md_illegal
    } tcsm_mode_t;

    typedef enum logic [2:0] {
        tcsm_trig_sw_only,
        tcsm_trig_one_edge,
        tcsm_trig_both_edges,
        tcsm_trig_master_irq,
        tcsm_trig_illegal
    } tcsm_trig_t;

    typedef enum logic [1:0] {
        tcsm_edge_fall,
        tcsm_edge_rise,
        tcsm_edge_both_low,
        tcsm_edge_both_high
    } tcsm_edge_t;

    typedef struct packed {
        logic [14:0] cnt;
        logic tick;
    } tcsm_div_state_t;

    typedef struct packed {
        logic [7:0][15:0] mode;
        logic [7:0] psel;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_prev;
        logic fsub_s1;
        logic fsub_s2;
        logic fsub_prev;
        logic [1:0] fsub_cnt;
        logic fsub_pulse;
        logic [7:0] op_en;
        logic [7:0] cnt_en;
        logic [7:0] count_up;
        logic [7:0] leader;
        tcsm_mode_t [7:0] chan_mode;
        tcsm_trig_t [7:0] trig;
        tcsm_edge_t [7:0] edge_sel;
        logic [15:0] rdata;
    } tcsm_state_t;

endpackage

// ---- tcsm_div_if.sv ----
// Purpose: select and tick between the top module and one prescaler
// Assumes: tick is a one-cycle enable on clk_sys
// Notes: none
interface tcsm_div_if;
    logic [3:0] sel;
    logic tick;
    modport ctrl (output sel, input tick);
    modport div (input sel, output tick);
endinterface

// ---- tcsm_prescaler.sv ----
// Purpose: free-running divider giving a one-cycle tick every 2**sel clocks
// Assumes: sel from the same clock domain
// Notes: tick is registered
module tcsm_prescaler
    import tcsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    tcsm_div_if.div dv
);
    tcsm_div_state_t st;
    tcsm_div_state_t next_st;
    logic [14:0] mask;

    always_comb begin
        mask = 15'((16'h0001 << dv.sel) - 16'h0001);
        next_st.cnt = st.cnt + 15'h0001;
        next_st.tick = (dv.sel == 4'h0) || ((st.cnt & mask) == mask);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dv.tick = st.tick;

    property p_div_full;
        @(posedge clk_sys) disable iff (!nrst)
        (nrst && dv.sel == 4'h0) [*2] |-> dv.tick;
    endproperty
    a_div_full: assert property (p_div_full) else $error("undivided tick missing");

    property p_div_gap;
        @(posedge clk_sys) disable iff (!nrst)
        (dv.sel != 4'h0 && $stable(dv.sel) && dv.tick) |=> !dv.tick;
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("divided tick too long");

    c_div_half: cover property (@(posedge clk_sys) disable iff (!nrst)
        (dv.sel == 4'h1) [*4] ##0 dv.tick);
endmodule

// ---- tcsm_top.sv ----
// Purpose: clock select and channel mode registers of an eight-channel timer array
// Assumes: cpu bus with byte write flag, 20-bit byte addresses, pins asynchronous
// Notes: decoded fields and clock enables lag the registers by one cycle
`include "tcsm_regs.svh"
module tcsm_top
    import tcsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [19:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_byte,
    input wire logic [15:0] cpu_wdata,
    input wire logic cpu_rd,
    output logic [15:0] cpu_rdata,
    input wire logic [7:0] channel_input_pin,
    input wire logic fsub_clk,
    input wire logic [7:0] sub_clock_route,
    output logic [7:0] channel_op_clock,
    output logic [7:0] channel_count_clock,
    output logic [7:0] count_up,
    output logic [7:0] group_leader_bit,
    output tcsm_mode_t [7:0] channel_mode_field,
    output tcsm_trig_t [7:0] start_trigger_field,
    output tcsm_edge_t [7:0] edge_select
);
    tcsm_state_t st;
    tcsm_state_t next_st;
    tcsm_div_if shared_clock_a ();
    tcsm_div_if shared_clock_b ();
    logic [19:0] off;
    logic mode_hit;
    logic [2:0] idx;
    logic psel_hit;
    logic fsub_rise;
    logic [7:0] pin_rise;
    logic [7:0] pin_fall;
    logic [7:0] edge_hit;
    logic [15:0] m;

    assign shared_clock_a.sel = st.psel[`TCSM_CLKA_HI:`TCSM_CLKA_LO];
    assign shared_clock_b.sel = st.psel[`TCSM_CLKB_HI:`TCSM_CLKB_LO];

    tcsm_prescaler u_clock_a (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .dv(shared_clock_a)
    );

    tcsm_prescaler u_clock_b (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .dv(shared_clock_b)
    );

    always_comb begin
        next_st = st;
        m = '0;
        edge_hit = '0;
        off = cpu_addr - `TCSM_MODE0_ADDR;
        idx = off[3:1];
        mode_hit = (cpu_addr >= `TCSM_MODE0_ADDR) && (cpu_addr <= `TCSM_MODE_LAST_ADDR)
            && !cpu_addr[0];
        psel_hit = (cpu_addr == `TCSM_PSEL_ADDR);
        // register writes
        if (cpu_wr && psel_hit) begin
            next_st.psel = cpu_wdata[7:0];
        end
        if (cpu_wr && mode_hit && !cpu_byte) begin
            next_st.mode[idx] = cpu_wdata & `TCSM_MODE_WMASK;
        end
        // register reads, unmapped reads give zero
        if (cpu_rd) begin
            next_st.rdata = '0;
            if (psel_hit) begin
                next_st.rdata = {8'h00, st.psel};
            end else if (mode_hit) begin
                next_st.rdata = st.mode[idx];
            end
        end
        // pin and subsystem clock synchronisers
        next_st.pin_s1 = channel_input_pin;
        next_st.pin_s2 = st.pin_s1;
        next_st.fsub_s1 = fsub_clk;
        next_st.fsub_s2 = st.fsub_s1;
        next_st.fsub_prev = st.fsub_s2;
        fsub_rise = st.fsub_s2 && !st.fsub_prev;
        next_st.fsub_pulse = 1'b0;
        if (fsub_rise) begin
            next_st.fsub_cnt = st.fsub_cnt + 2'h1;
            next_st.fsub_pulse = (st.fsub_cnt == `TCSM_FSUB_DIV);
        end
        pin_rise = st.pin_s2 & ~st.pin_prev;
        pin_fall = ~st.pin_s2 & st.pin_prev;
        for (int n = 0; n < 8; n++) begin
            m = st.mode[n];
            next_st.op_en[n] = m[`TCSM_CKS_BIT] ? shared_clock_b.tick
                : shared_clock_a.tick;
            if (st.op_en[n]) begin
                next_st.pin_prev[n] = st.pin_s2[n];
            end
            unique case (st.edge_sel[n])
                tcsm_edge_fall: edge_hit[n] = pin_fall[n];
                tcsm_edge_rise: edge_hit[n] = pin_rise[n];
                tcsm_edge_both_low, tcsm_edge_both_high: edge_hit[n] = pin_rise[n] | pin_fall[n];
            endcase
            if (!m[`TCSM_CCS_BIT]) begin
                next_st.cnt_en[n] = st.op_en[n];
            end else if (sub_clock_route[n]) begin
                next_st.cnt_en[n] = st.fsub_pulse;
            end else begin
                next_st.cnt_en[n] = st.op_en[n] && edge_hit[n];
            end
            next_st.leader[n] = m[`TCSM_LEAD_BIT];
            next_st.edge_sel[n] = tcsm_edge_t'(m[`TCSM_EDGE_HI:`TCSM_EDGE_LO]);
            unique case (m[`TCSM_TRIG_HI:`TCSM_TRIG_LO])
                3'h0: next_st.trig[n] = tcsm_trig_sw_only;
                3'h1: next_st.trig[n] = tcsm_trig_one_edge;
                3'h2: next_st.trig[n] = tcsm_trig_both_edges;
                3'h4: next_st.trig[n] = tcsm_trig_master_irq;
                default: next_st.trig[n] = tcsm_trig_illegal;
            endcase
            unique case (m[`TCSM_MD_HI:`TCSM_MD_LO + 1])
                3'h0: next_st.chan_mode[n] = tcsm_md_interval;
                3'h2: next_st.chan_mode[n] = tcsm_md_capture;
                3'h3: next_st.chan_mode[n] = m[0] ? tcsm_md_illegal : tcsm_md_event;
                3'h4: next_st.chan_mode[n] = tcsm_md_one_count;
                3'h6: next_st.chan_mode[n] = m[0] ? tcsm_md_illegal : tcsm_md_capture_one;
                default: next_st.chan_mode[n] = tcsm_md_illegal;
            endcase
            next_st.count_up[n] = (m[`TCSM_MD_HI:`TCSM_MD_LO + 1] == 3'h2)
                || (m[`TCSM_MD_HI:`TCSM_MD_LO + 1] == 3'h6);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.psel <= `TCSM_PSEL_RESET;
            st.mode <= {8{`TCSM_MODE_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign cpu_rdata = st.rdata;
    assign channel_op_clock = st.op_en;
    assign channel_count_clock = st.cnt_en;
    assign count_up = st.count_up;
    assign group_leader_bit = st.leader;
    assign channel_mode_field = st.chan_mode;
    assign start_trigger_field = st.trig;
    assign edge_select = st.edge_sel;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_psel_reset;
        !$past(nrst) |-> st.psel == 8'h00 && shared_clock_a.sel == 4'h0;
    endproperty
    a_psel_reset: assert property (p_psel_reset) else $error("select not zero after reset");

    property p_psel_write;
        cpu_wr && cpu_addr == `TCSM_PSEL_ADDR |=> st.psel == $past(cpu_wdata[7:0]);
    endproperty
    a_psel_write: assert property (p_psel_write) else $error("select write lost");

    property p_psel_read;
        cpu_rd && cpu_addr == `TCSM_PSEL_ADDR && !cpu_wr |=>
            cpu_rdata == {8'h00, $past(st.psel)};
    endproperty
    a_psel_read: assert property (p_psel_read) else $error("select read wrong");

    property p_mode_byte;
        cpu_wr && cpu_byte && cpu_addr == `TCSM_MODE0_ADDR |=> $stable(st.mode[0]);
    endproperty
    a_mode_byte: assert property (p_mode_byte) else $error("byte write changed mode");

    property p_op_sel;
        1'b1 |=> channel_op_clock[0] == ($past(st.mode[0][15]) ? $past(shared_clock_b.tick)
            : $past(shared_clock_a.tick));
    endproperty
    a_op_sel: assert property (p_op_sel) else $error("operation clock select wrong");

    property p_cnt_op;
        !st.mode[0][`TCSM_CCS_BIT] && channel_op_clock[0] |=> channel_count_clock[0];
    endproperty
    a_cnt_op: assert property (p_cnt_op) else $error("count clock missed tick");

    property p_cnt_edge;
        st.mode[3][`TCSM_CCS_BIT] && !sub_clock_route[3] && channel_count_clock[3]
            |-> $past(channel_op_clock[3]);
    endproperty
    a_cnt_edge: assert property (p_cnt_edge) else $error("edge count off operation clock");

    property p_leader;
        1'b1 |=> group_leader_bit[2] == $past(st.mode[2][11]);
    endproperty
    a_leader: assert property (p_leader) else $error("leader bit wrong");

    property p_capture_up;
        cpu_wr && !cpu_byte && cpu_addr == `TCSM_MODE0_ADDR + 20'h2 && cpu_wdata[3:1] == 3'h2
            |-> ##2 count_up[1] && channel_mode_field[1] == tcsm_md_capture;
    endproperty
    a_capture_up: assert property (p_capture_up) else $error("capture mode decode wrong");

    property p_trig_bad;
        cpu_wr && !cpu_byte && cpu_addr == `TCSM_MODE0_ADDR + 20'ha && cpu_wdata[10:8] == 3'h7
            |-> ##2 start_trigger_field[5] == tcsm_trig_illegal;
    endproperty
    a_trig_bad: assert property (p_trig_bad) else $error("prohibited trigger not flagged");

    c_clock_b: cover property (st.mode[1][15] && channel_op_clock[1]);
    c_edge_count: cover property (st.mode[3][12] && channel_count_clock[3]);
    c_byte_alias: cover property (cpu_wr && cpu_byte && cpu_addr == `TCSM_PSEL_ADDR);
endmodule

// ---- tcsm_top_test.sv ----
// Purpose: self-checking bench of the timer clock select and channel mode registers
// Assumes: 200 MHz clk_sys, one-cycle cpu strobes, fsub much slower than clk_sys
// Notes: upper select byte and unused mode bits read back as zero
`include "tcsm_regs.svh"
module tcsm_top_test import tcsm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, nrst, cpu_wr, cpu_byte, cpu_rd, fsub_clk;
    logic [19:0] cpu_addr;
    logic [15:0] cpu_wdata, cpu_rdata, v;
    logic [7:0] channel_input_pin, sub_clock_route, channel_op_clock, channel_count_clock;
    logic [7:0] count_up, group_leader_bit;
    tcsm_mode_t [7:0] channel_mode_field;
    tcsm_trig_t [7:0] start_trigger_field;
    tcsm_edge_t [7:0] edge_select;
    int fail_count, tests_run, cnt2, cnt3;
    logic [3:0] md_code [6] = '{4'h1, 4'h5, 4'h6, 4'h9, 4'hc, 4'he};
    tcsm_mode_t md_exp [6] = '{tcsm_md_interval, tcsm_md_capture, tcsm_md_event,
        tcsm_md_one_count, tcsm_md_capture_one, tcsm_md_illegal};
    logic up_exp [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [2:0] tr_code [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h7};
    tcsm_trig_t tr_exp [6] = '{tcsm_trig_sw_only, tcsm_trig_one_edge, tcsm_trig_both_edges,
        tcsm_trig_master_irq, tcsm_trig_illegal, tcsm_trig_illegal};

    tcsm_top tcsm_top_i (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr),
        .cpu_byte(cpu_byte),
        .cpu_wdata(cpu_wdata),
        .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata),
        .channel_input_pin(channel_input_pin),
        .fsub_clk(fsub_clk),
        .sub_clock_route(sub_clock_route),
        .channel_op_clock(channel_op_clock),
        .channel_count_clock(channel_count_clock),
        .count_up(count_up),
        .group_leader_bit(group_leader_bit),
        .channel_mode_field(channel_mode_field),
        .start_trigger_field(start_trigger_field),
        .edge_select(edge_select)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic b);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_byte <= b;
        cpu_wr <= 1'b1;
        @(posedge clk_sys);
        cpu_wr <= 1'b0;
    endtask

    task automatic rd(input logic [19:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge clk_sys);
        cpu_rd <= 1'b0;
        #1;
        check(cpu_rdata, exp);
    endtask

    // gap between op clock pulses; count clock must trail op clock by one cycle
    task automatic period(input int ch, input int exp);
        int n;
        int lag;
        logic prev;
        n = 0;
        lag = 0;
        prev = 1'b1;
        repeat (8) @(posedge clk_sys);
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (channel_op_clock[ch] !== 1'b1 && n < 70000);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
            if (channel_count_clock[ch] !== prev) lag++;
            prev = channel_op_clock[ch];
        end while (channel_op_clock[ch] !== 1'b1 && n < 70000);
        check(16'(n), 16'(exp));
        check(16'(lag), 16'h0000);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end

    initial begin
        nrst = 1'b0;
        cpu_addr = 20'h00000;
        cpu_wr = 1'b0;
        cpu_byte = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 16'h0000;
        fsub_clk = 1'b0;
        channel_input_pin = 8'h00;
        sub_clock_route = 8'h00;
        fail_count = 0;
        tests_run = 0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(`TCSM_PSEL_ADDR, 16'h0000);
        for (int i = 0; i < 8; i++) rd(`TCSM_MODE0_ADDR + 20'(2 * i), 16'h0000);
        wr(`TCSM_PSEL_ADDR, 16'h005a, 1'b0);
        rd(`TCSM_PSEL_ADDR, 16'h005a);
        wr(`TCSM_PSEL_ADDR, 16'h0037, 1'b1);
        wr(`TCSM_PSEL_ADDR + 20'h1, 16'h0000, 1'b1);
        rd(`TCSM_PSEL_ADDR, 16'h0037);
        wr(`TCSM_MODE_LAST_ADDR, 16'h97cf, 1'b0);
        rd(`TCSM_MODE_LAST_ADDR, 16'h97cf);
        wr(`TCSM_MODE_LAST_ADDR, 16'h0000, 1'b1);
        rd(`TCSM_MODE_LAST_ADDR, 16'h97cf);
        rd(20'hf01a0, 16'h0000);
        // every decoded mode, trigger and edge value on its own channel
        for (int i = 0; i < 6; i++) begin
            v = {4'h0, (i % 2 == 0), tr_code[i], 2'(i % 4), 2'b00, md_code[i]};
            wr(`TCSM_MODE0_ADDR + 20'(2 * i), v, 1'b0);
            repeat (3) @(posedge clk_sys);
            #1;
            check(16'(channel_mode_field[i]), 16'(md_exp[i]));
            check(16'(count_up[i]), 16'(up_exp[i]));
            check(16'(start_trigger_field[i]), 16'(tr_exp[i]));
            check(16'(edge_select[i]), 16'(i % 4));
            check(16'(group_leader_bit[i]), 16'(i % 2 == 0));
        end
        wr(`TCSM_MODE0_ADDR, 16'h0000, 1'b0);
        wr(`TCSM_MODE0_ADDR + 20'h2, 16'h8000, 1'b0);
        wr(`TCSM_PSEL_ADDR, 16'h0041, 1'b0);
        period(0, 2);
        period(1, 16);
        wr(`TCSM_PSEL_ADDR, 16'h0090, 1'b0);
        period(0, 1);
        period(1, 512);
        wr(`TCSM_PSEL_ADDR, 16'h000f, 1'b0);
        period(0, 32768);
        // count source: fsub divided by four on channel 2, rising pin edges on channel 3
        wr(`TCSM_PSEL_ADDR, 16'h0000, 1'b0);
        wr(`TCSM_MODE0_ADDR + 20'h4, 16'h1000, 1'b0);
        wr(`TCSM_MODE0_ADDR + 20'h6, 16'h1040, 1'b0);
        sub_clock_route <= 8'h04;
        cnt2 = 0;
        cnt3 = 0;
        fork
            repeat (16) begin
                repeat (20) @(posedge clk_sys);
                fsub_clk <= 1'b1;
                repeat (20) @(posedge clk_sys);
                fsub_clk <= 1'b0;
            end
            repeat (4) begin
                repeat (20) @(posedge clk_sys);
                channel_input_pin[3] <= 1'b1;
                repeat (20) @(posedge clk_sys);
                channel_input_pin[3] <= 1'b0;
            end
            repeat (700) begin
                @(posedge clk_sys);
                #1;
                cnt2 += int'(channel_count_clock[2]);
                cnt3 += int'(channel_count_clock[3]);
            end
        join
        check(16'(cnt3), 16'h0004);
        check(16'(cnt2), 16'h0004);
        give_verdict();
    end
endmodule
